// file: rtl/cgcs_pkg.sv
// package for the can global control and status block
// Notes on behaviour
// - setting enable bit switches the controller on and ungates its clock
// - clearing enable lets a frame in progress finish before stopping
// - disable freezes protocol state; channel-enable bits stay untouched
// - in standby the transmit output stays recessive
// - in standby the receive path is off and internal clock stopped
// - registers and object storage stay accessible while disabled
// - protocol machine needs two clock periods after enable to run
// - enable-state flag shows the mode really reached; no interrupt
// - overload flag held while sending own overload frame; no interrupt
// - transmitter-busy set while driving any frame or acknowledge field
// - transmitter-busy also set in interframe space with frame pending
// - global status is read-only at special-function address AAh
// - reset clears global control to zero, controller disabled
// - reset clears defined status bits; reserved bits 7 and 5 always read as zero
package cgcs_pkg;
  localparam logic [7:0] CGCS_ADDR_STATUS = 8'hAA;
  localparam logic [7:0] CGCS_ADDR_CONTROL = 8'hAB;
  localparam logic [7:0] CGCS_CTRL_RESET = 8'h00;
  localparam logic [7:0] CGCS_CTRL_WMASK = 8'h0F;
  localparam int CGCS_BIT_LISTEN = 3;
  localparam int CGCS_BIT_TEST = 2;
  localparam int CGCS_BIT_ENABLE = 1;
  localparam int CGCS_BIT_SRST = 0;
  localparam int CGCS_START_CYCLES = 2;
  localparam logic [1:0] CGCS_START_LAST = 2'h1;
  localparam logic [1:0] CGCS_CNT_ZERO = 2'h0;
  localparam logic [1:0] CGCS_CNT_ONE = 2'h1;

  typedef struct packed {
    logic tx_frame;
    logic tx_pending;
    logic in_frame;
    logic overload_tx;
    logic rx_busy;
    logic bus_off;
    logic err_passive;
  } cgcs_core_s;

  typedef struct packed {
    logic rsv7;
    logic overload_sending_flag;
    logic rsv5;
    logic transmitter_busy_flag;
    logic receiver_busy_flag;
    logic enable_state_flag;
    logic bus_off_flag;
    logic error_passive_flag;
  } cgcs_status_s;

  typedef enum logic [1:0] {
    CGCS_STANDBY,
    CGCS_STARTING,
    CGCS_RUNNING,
    CGCS_STOPPING
  } cgcs_mode_e;
endpackage : cgcs_pkg

// file: rtl/cgcs_global.sv
// global control/status registers and enable sequencing of the can core
`timescale 1ns/10ps
module cgcs_global (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire cgcs_pkg::cgcs_core_s core_stat,
  input wire logic core_tx_bit,
  input wire logic core_tx_ack_err,
  output logic can_tx,
  output logic core_clk_en,
  output logic core_rx_en,
  output logic core_run,
  output logic core_reset,
  output logic core_listen_only,
  output logic core_test_mode
);
  import cgcs_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  cgcs_mode_e mode_q;
  cgcs_mode_e mode_d;
  logic [1:0] start_cnt_q;
  cgcs_status_s status_d;
  logic enable_cmd;
  logic ctrl_wr;

  assign ctrl_wr = sfr_wr && (sfr_addr == CGCS_ADDR_CONTROL);
  assign enable_cmd = ctrl_q[CGCS_BIT_ENABLE];

  // registers stay writable in any mode; status writes are dropped
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = sfr_wdata & CGCS_CTRL_WMASK;
    end else begin
      ctrl_d[CGCS_BIT_SRST] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CGCS_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // mode sequencing: stop waits for the frame, start takes two cycles
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CGCS_STANDBY: begin
        if (enable_cmd) begin
          mode_d = CGCS_STARTING;
        end
      end
      CGCS_STARTING: begin
        if (!enable_cmd) begin
          mode_d = CGCS_STANDBY;
        end else if (start_cnt_q == CGCS_START_LAST) begin
          mode_d = CGCS_RUNNING;
        end
      end
      CGCS_RUNNING: begin
        if (!enable_cmd) begin
          mode_d = CGCS_STOPPING;
        end
      end
      CGCS_STOPPING: begin
        if (enable_cmd) begin
          mode_d = CGCS_RUNNING;
        end else if (!core_stat.in_frame) begin
          mode_d = CGCS_STANDBY;
        end
      end
      default: begin
        mode_d = CGCS_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= CGCS_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      start_cnt_q <= CGCS_CNT_ZERO;
    end else if (mode_q == CGCS_STARTING) begin
      start_cnt_q <= start_cnt_q + CGCS_CNT_ONE;
    end else begin
      start_cnt_q <= CGCS_CNT_ZERO;
    end
  end

  // gating stops the core clock and receive path; core state is frozen, not cleared,
  // and object channel-enable bits are never touched from here
  always_ff @(posedge clk) begin
    if (srst) begin
      core_clk_en <= 1'b0;
      core_rx_en <= 1'b0;
      core_run <= 1'b0;
    end else begin
      core_clk_en <= (mode_d != CGCS_STANDBY);
      core_rx_en <= (mode_d != CGCS_STANDBY);
      core_run <= (mode_d == CGCS_RUNNING) || (mode_d == CGCS_STOPPING);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_reset <= 1'b1;
      core_listen_only <= 1'b0;
      core_test_mode <= 1'b0;
    end else begin
      core_reset <= ctrl_d[CGCS_BIT_SRST];
      core_listen_only <= ctrl_d[CGCS_BIT_LISTEN];
      core_test_mode <= ctrl_d[CGCS_BIT_TEST];
    end
  end

  // recessive is logic one; listen-only suppresses ack and error drive
  always_ff @(posedge clk) begin
    if (srst) begin
      can_tx <= 1'b1;
    end else if (mode_d == CGCS_STANDBY) begin
      can_tx <= 1'b1;
    end else if (ctrl_d[CGCS_BIT_LISTEN] && core_tx_ack_err) begin
      can_tx <= 1'b1;
    end else begin
      can_tx <= core_tx_bit;
    end
  end

  // reserved bits read as zero
  always_comb begin
    status_d = '0;
    status_d.overload_sending_flag = core_stat.overload_tx;
    status_d.transmitter_busy_flag = core_stat.tx_frame
      || (core_stat.tx_pending && !core_stat.in_frame);
    status_d.receiver_busy_flag = core_stat.rx_busy;
    status_d.enable_state_flag = (mode_q == CGCS_RUNNING)
      || (mode_q == CGCS_STOPPING);
    status_d.bus_off_flag = core_stat.bus_off;
    status_d.error_passive_flag = core_stat.err_passive;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == CGCS_ADDR_STATUS) begin
      sfr_rdata <= status_d;
    end else if (sfr_rd && sfr_addr == CGCS_ADDR_CONTROL) begin
      sfr_rdata <= ctrl_q;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // read data seen through the status layout for the flag checks
  cgcs_status_s rd_view;
  logic stat_rd;
  assign rd_view = sfr_rdata;
  assign stat_rd = sfr_rd && (sfr_addr == CGCS_ADDR_STATUS);

  a_standby_recessive: assert property (
    @(posedge clk) disable iff (srst)
    mode_q == CGCS_STANDBY |-> can_tx)
    else $error("tx not recessive in standby");

  a_clock_gated: assert property (
    @(posedge clk) disable iff (srst)
    mode_q == CGCS_STANDBY |-> !core_clk_en && !core_rx_en)
    else $error("core clock or receiver running in standby");

  a_clock_run_mode: assert property (
    @(posedge clk) disable iff (srst)
    mode_q != CGCS_STANDBY |-> core_clk_en && core_rx_en)
    else $error("core clock gated while enabled");

  a_enable_wakes: assert property (
    @(posedge clk) disable iff (srst)
    enable_cmd && mode_q == CGCS_STANDBY |=> core_clk_en)
    else $error("enable did not ungate the core clock");

  a_start_two_cycles: assert property (
    @(posedge clk) disable iff (srst)
    (mode_q == CGCS_STANDBY) ##1 (mode_q == CGCS_STARTING) [*2]
      |=> mode_q == CGCS_RUNNING || !$past(enable_cmd))
    else $error("start did not take two cycles");

  a_no_run_early: assert property (
    @(posedge clk) disable iff (srst)
    $rose(enable_cmd) && mode_q == CGCS_STANDBY |=> !core_run ##1 !core_run)
    else $error("protocol machine ran too early");

  a_run_after_start: assert property (
    @(posedge clk) disable iff (srst)
    mode_q == CGCS_STARTING && start_cnt_q == CGCS_START_LAST
      && enable_cmd |=> mode_q == CGCS_RUNNING && core_run)
    else $error("protocol machine late after start");

  a_stop_waits_frame: assert property (
    @(posedge clk) disable iff (srst)
    mode_q == CGCS_STOPPING && core_stat.in_frame && !enable_cmd
      |=> mode_q == CGCS_STOPPING)
    else $error("stopped during a frame");

  a_stop_keeps_clock: assert property (
    @(posedge clk) disable iff (srst)
    mode_q == CGCS_STOPPING |-> core_clk_en && core_run)
    else $error("core halted before frame end");

  a_stop_ends: assert property (
    @(posedge clk) disable iff (srst)
    mode_q == CGCS_STOPPING && !core_stat.in_frame && !enable_cmd
      |=> mode_q == CGCS_STANDBY && !core_clk_en && !core_run)
    else $error("core not frozen after frame end");

  a_ctrl_write: assert property (
    @(posedge clk) disable iff (srst)
    ctrl_wr |=> ctrl_q == ($past(sfr_wdata) & CGCS_CTRL_WMASK))
    else $error("control write did not land");

  a_ctrl_readback: assert property (
    @(posedge clk) disable iff (srst)
    sfr_rd && sfr_addr == CGCS_ADDR_CONTROL |=> sfr_rdata == $past(ctrl_q))
    else $error("control read returned wrong data");

  a_status_ro: assert property (
    @(posedge clk) disable iff (srst)
    sfr_wr && sfr_addr == CGCS_ADDR_STATUS && !ctrl_q[CGCS_BIT_SRST]
      |=> $stable(ctrl_q))
    else $error("status write changed a register");

  a_soft_reset_clear: assert property (
    @(posedge clk) disable iff (srst)
    ctrl_q[CGCS_BIT_SRST] && !ctrl_wr |=> !ctrl_q[CGCS_BIT_SRST])
    else $error("soft reset bit did not self-clear");

  a_soft_reset_pulse: assert property (
    @(posedge clk) disable iff (srst)
    ctrl_wr && sfr_wdata[CGCS_BIT_SRST] ##1 !ctrl_wr
      |-> core_reset ##1 !core_reset)
    else $error("core reset not a single pulse");

  a_listen_reg: assert property (
    @(posedge clk) disable iff (srst)
    ctrl_wr |=> core_listen_only == $past(sfr_wdata[CGCS_BIT_LISTEN]))
    else $error("listen bit not passed to the core");

  a_listen_quiet: assert property (
    @(posedge clk) disable iff (srst)
    $past(ctrl_d[CGCS_BIT_LISTEN]) && $past(core_tx_ack_err) |-> can_tx)
    else $error("listen-only drove ack or error");

  a_enable_flag: assert property (
    @(posedge clk) disable iff (srst)
    $rose(mode_q == CGCS_RUNNING) && $past(mode_q) == CGCS_STARTING
      |-> $past(enable_cmd, 3))
    else $error("enable flag ahead of command");

  a_run_flag: assert property (
    @(posedge clk) disable iff (srst)
    core_run == (mode_q == CGCS_RUNNING || mode_q == CGCS_STOPPING))
    else $error("run output disagrees with mode");

  a_enable_state: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd |=> rd_view.enable_state_flag == $past(core_run))
    else $error("enable-state flag wrong");

  a_overload_flag: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd |=> rd_view.overload_sending_flag == $past(core_stat.overload_tx))
    else $error("overload flag wrong");

  a_tx_busy_frame: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd && core_stat.tx_frame |=> rd_view.transmitter_busy_flag)
    else $error("transmitter busy missing during frame");

  a_tx_busy_pending: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd && core_stat.tx_pending && !core_stat.in_frame
      |=> rd_view.transmitter_busy_flag)
    else $error("transmitter busy missing with frame pending");

  a_rx_busy_flag: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd |=> rd_view.receiver_busy_flag == $past(core_stat.rx_busy))
    else $error("receiver busy flag wrong");

  a_fault_flags: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd |=> rd_view.bus_off_flag == $past(core_stat.bus_off)
      && rd_view.error_passive_flag == $past(core_stat.err_passive))
    else $error("fault confinement flags wrong");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (srst)
    stat_rd |=> !rd_view.rsv7 && !rd_view.rsv5)
    else $error("reserved status bits not zero");

  a_ctrl_reset: assert property (
    @(posedge clk)
    srst |=> ctrl_q == CGCS_CTRL_RESET && mode_q == CGCS_STANDBY)
    else $error("control not cleared by reset");

  a_reset_outputs: assert property (
    @(posedge clk)
    srst |=> can_tx && core_reset && !core_clk_en && !core_run)
    else $error("outputs not at reset levels");

  a_status_reset: assert property (
    @(posedge clk)
    srst |=> sfr_rdata == '0 && !core_listen_only && !core_test_mode)
    else $error("read data or options not cleared by reset");
endmodule : cgcs_global

// file: tb/cgcs_core_model.sv
// behavioural can core and bus partner driven from the bench
`timescale 1ns/10ps
module cgcs_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic core_clk_en,
  input wire logic [8:0] req,
  output cgcs_pkg::cgcs_core_s core_stat,
  output logic core_tx_bit,
  output logic core_tx_ack_err
);
  import cgcs_pkg::*;
  // core only moves while its clock is ungated
  always_ff @(posedge clk) begin
    if (srst) begin
      {core_stat, core_tx_bit, core_tx_ack_err} <= 9'h002;
    end else if (core_clk_en) begin
      {core_stat, core_tx_bit, core_tx_ack_err} <= req;
    end
  end
endmodule : cgcs_core_model

// file: tb/testbench.sv
// self-checking bench for the can global control and status block
`timescale 1ns/10ps
module testbench;
  import cgcs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [8:0] req = 9'h002;
  cgcs_core_s core_stat;
  logic core_tx_bit;
  logic core_tx_ack_err;
  logic can_tx;
  logic core_clk_en;
  logic core_rx_en;
  logic core_run;
  logic core_reset;
  logic core_listen_only;
  logic core_test_mode;
  logic r0;
  logic [7:0] exp_v;
  int n_errors = 0;
  int cmp_count = 0;

  cgcs_global i_dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .core_stat(core_stat),
    .core_tx_bit(core_tx_bit), .core_tx_ack_err(core_tx_ack_err),
    .can_tx(can_tx), .core_clk_en(core_clk_en), .core_rx_en(core_rx_en),
    .core_run(core_run), .core_reset(core_reset),
    .core_listen_only(core_listen_only), .core_test_mode(core_test_mode));
  cgcs_core_model i_core (.clk(clk), .srst(srst), .core_clk_en(core_clk_en),
    .req(req), .core_stat(core_stat), .core_tx_bit(core_tx_bit),
    .core_tx_ack_err(core_tx_ack_err));

  initial begin
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] exp_stat(logic [8:0] r, logic en);
    return {1'b0, r[5], 1'b0, r[8] | (r[7] & ~r[6]), r[4], en, r[3], r[2]};
  endfunction : exp_stat

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
  endtask : rd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(15));
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    rd(CGCS_ADDR_CONTROL);
    check("ctrl", sfr_rdata, CGCS_CTRL_RESET);
    rd(CGCS_ADDR_STATUS);
    check("stat", sfr_rdata, 8'h00);
    check("can_tx", can_tx, 8'h01);
    wr(CGCS_ADDR_CONTROL, 8'h04);
    rd(CGCS_ADDR_CONTROL);
    check("ctrl", sfr_rdata, 8'h04);
    check("test", core_test_mode, 8'h01);
    wr(CGCS_ADDR_CONTROL, 8'h05);
    r0 = core_reset;
    cyc(1);
    check("sreset", r0 ^ core_reset, 8'h01);
    rd(CGCS_ADDR_CONTROL);
    check("ctrl", sfr_rdata, 8'h04);
    $display("registers test done");
    wr(CGCS_ADDR_CONTROL, 8'h02);
    check("clk_en", core_clk_en, 8'h00);
    cyc(1);
    check("clk_en", core_clk_en, 8'h01);
    check("run", core_run, 8'h00);
    cyc(1);
    check("run", core_run, 8'h00);
    cyc(1);
    check("run", core_run, 8'h01);
    check("rx_en", core_rx_en, 8'h01);
    $display("enable test done");
    repeat (16) begin
      req = 9'($urandom) | 9'h002;
      cyc(2);
      rd(CGCS_ADDR_STATUS);
      exp_v = exp_stat(req, 1'b1);
      check("stat", sfr_rdata, exp_v);
    end
    // status flags stay unchanged on an ignored write
    wr(CGCS_ADDR_STATUS, 8'h5F);
    rd(CGCS_ADDR_STATUS);
    check("stat", sfr_rdata, exp_stat(req, 1'b1));
    $display("status test done");
    wr(CGCS_ADDR_CONTROL, 8'h0A);
    req = 9'h001;
    cyc(3);
    check("listen", core_listen_only, 8'h01);
    check("can_tx", can_tx, 8'h01);
    req = 9'h000;
    cyc(3);
    check("can_tx", can_tx, 8'h00);
    $display("listen test done");
    wr(CGCS_ADDR_CONTROL, 8'h02);
    req = 9'h040;
    cyc(2);
    wr(CGCS_ADDR_CONTROL, 8'h00);
    cyc(3);
    rd(CGCS_ADDR_STATUS);
    check("stat", sfr_rdata, exp_stat(req, 1'b1));
    req = 9'h000;
    cyc(4);
    check("clk_en", core_clk_en, 8'h00);
    check("rx_en", core_rx_en, 8'h00);
    check("can_tx", can_tx, 8'h01);
    rd(CGCS_ADDR_STATUS);
    check("stat", sfr_rdata, exp_stat(req, 1'b0));
    // core clock is gated, so new core activity must not show up
    req = 9'($urandom) | 9'h002;
    cyc(3);
    rd(CGCS_ADDR_STATUS);
    check("frozen", sfr_rdata, exp_stat(9'h000, 1'b0));
    $display("standby test done");
    wrap_up();
  end
endmodule : testbench
